// File: rtl/pfm_pin_mux.sv
`timescale 1ns/1ps
// How it works
// - Data select pin goes low during every external data-memory access, high otherwise.
// - Chip select one comes out of reset acting as the data-memory select.
// - Idle bus: select pins float or stay driven per the bus drive bit.
// - Chip selects two and three assert for programmed external memory regions.
// - Each general-purpose pin has its own direction bit.
// - CAN transmit pin resets as GPIO; enable bit 0 then select bit 4.
// - CAN receive pin resets as GPIO; enable bit 1 then select bit 5.
// - Port D pull-up bits 9, 0, 1 clear to drop select pin pull-ups.
// - Port E pull-up bits 0, 1 clear to drop serial pin pull-ups.
// - Serial zero pins default to serial function after reset.
module pfm_pin_mux (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// External-memory interface side.
	input wire logic extDataAccess,
	input wire logic extBusActive,
	input wire logic [1:0] csRegionHit,
	input wire logic [1:0] csProgramEnable,
	input wire logic busDriveControl,
	// Configuration bits.
	input wire logic [15:0] portDPeripheralEnable,
	input wire logic [15:0] peripheralSelect,
	input wire logic [15:0] portDPullupEnable,
	input wire logic [15:0] portEPullupEnable,
	input wire logic [1:0] portESerialDisable,
	// General-purpose port data and direction.
	input wire logic [2:0] portDOut,
	input wire logic [2:0] portDDir,
	output logic [2:0] portDIn,
	input wire logic [1:0] portEOut,
	input wire logic [1:0] portEDir,
	output logic [1:0] portEIn,
	// Peripheral side.
	input wire logic canTx,
	output logic canRx,
	input wire logic serialTx,
	output logic serialRx,
	// Port D pins nine, zero, one.
	input wire logic [2:0] portDPinIn,
	output logic [2:0] portDPinOut,
	output logic [2:0] portDPinOe,
	output logic [2:0] portDPinPullup,
	// Port E pins zero, one.
	input wire logic [1:0] portEPinIn,
	output logic [1:0] portEPinOut,
	output logic [1:0] portEPinOe,
	output logic [1:0] portEPinPullup
);
	logic [4:0] pinLevel;
	logic canTxSel_r;
	logic canRxSel_r;
	logic [1:0] serialSel_r;
	logic [2:0] dOut_r;
	logic [2:0] dOe_r;
	logic [1:0] eOut_r;
	logic [1:0] eOe_r;
	logic [2:0] dPu_r;
	logic [1:0] ePu_r;
	logic dataSel;
	logic [1:0] csSel;
	logic selDrive;

	pfm_pin_sync #(
		.WIDTH(5)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.pinIn({portEPinIn, portDPinIn}),
		.pinLevel(pinLevel)
	);

	// ***********************************************************************
	// Function routing.
	// ***********************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			canTxSel_r <= 1'b0;
			canRxSel_r <= 1'b0;
			serialSel_r <= pfm_pkg::PORTE_SERIAL_RESET;
		end
		else
		begin
			canTxSel_r <= portDPeripheralEnable[pfm_pkg::PORTD_PER_CAN_TX_BIT]
				& peripheralSelect[pfm_pkg::PSEL_CAN_TX_BIT];
			canRxSel_r <= portDPeripheralEnable[pfm_pkg::PORTD_PER_CAN_RX_BIT]
				& peripheralSelect[pfm_pkg::PSEL_CAN_RX_BIT];
			serialSel_r <= ~portESerialDisable;
		end
	end

	// ***********************************************************************
	// Select generation.
	// ***********************************************************************
	always_comb
	begin
		dataSel = ~extDataAccess;
		csSel[0] = selectLevel(csRegionHit[0], csProgramEnable[0]);
		csSel[1] = selectLevel(csRegionHit[1], csProgramEnable[1]);
		selDrive = extBusActive | busDriveControl;
	end

	// ***********************************************************************
	// Chip-select level, low while its programmed region is hit.
	// ***********************************************************************
	function automatic logic selectLevel(input logic hit, input logic enabled);
		return ~(hit & enabled);
	endfunction

	// ***********************************************************************
	// Port D pin drivers, registered; all off in reset.
	// ***********************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dOut_r <= 3'h7;
			dOe_r <= 3'h0;
		end
		else
		begin
			dOut_r[0] <= dataSel;
			dOe_r[0] <= selDrive;
			if (canTxSel_r)
			begin
				dOut_r[1] <= 1'b0;
				dOe_r[1] <= ~canTx;
			end
			else if (!csProgramEnable[0])
			begin
				dOut_r[1] <= portDOut[1];
				dOe_r[1] <= portDDir[1];
			end
			else
			begin
				dOut_r[1] <= csSel[0];
				dOe_r[1] <= selDrive;
			end
			if (canRxSel_r)
			begin
				dOut_r[2] <= 1'b1;
				dOe_r[2] <= 1'b0;
			end
			else if (!csProgramEnable[1])
			begin
				dOut_r[2] <= portDOut[2];
				dOe_r[2] <= portDDir[2];
			end
			else
			begin
				dOut_r[2] <= csSel[1];
				dOe_r[2] <= selDrive;
			end
		end
	end

	// ***********************************************************************
	// Port E pin drivers, registered; all off in reset.
	// ***********************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			eOut_r <= 2'h3;
			eOe_r <= 2'h0;
		end
		else
		begin
			eOut_r[0] <= serialSel_r[0] ? serialTx : portEOut[0];
			eOe_r[0] <= serialSel_r[0] ? 1'b1 : portEDir[0];
			eOut_r[1] <= portEOut[1];
			eOe_r[1] <= serialSel_r[1] ? 1'b0 : portEDir[1];
		end
	end

	// ***********************************************************************
	// Pull-ups, all on in reset.
	// ***********************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dPu_r <= 3'h7;
			ePu_r <= 2'h3;
		end
		else
		begin
			dPu_r <= {portDPullupEnable[pfm_pkg::PORTD_PU_SELTHREE_BIT],
				portDPullupEnable[pfm_pkg::PORTD_PU_SELTWO_BIT],
				portDPullupEnable[pfm_pkg::PORTD_PU_DSEL_BIT]};
			ePu_r <= {portEPullupEnable[pfm_pkg::PORTE_PU_RX_BIT],
				portEPullupEnable[pfm_pkg::PORTE_PU_TX_BIT]};
		end
	end

	// ***********************************************************************
	// Inputs back to port and peripherals.
	// ***********************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			portDIn <= 3'h7;
			portEIn <= 2'h3;
			canRx <= 1'b1;
			serialRx <= 1'b1;
		end
		else
		begin
			portDIn <= pinLevel[2:0];
			portEIn <= pinLevel[4:3];
			canRx <= canRxSel_r ? pinLevel[2] : 1'b1;
			serialRx <= serialSel_r[1] ? pinLevel[4] : 1'b1;
		end
	end

	assign portDPinOut = dOut_r;
	assign portDPinOe = dOe_r;
	assign portDPinPullup = dPu_r;
	assign portEPinOut = eOut_r;
	assign portEPinOe = eOe_r;
	assign portEPinPullup = ePu_r;
endmodule

// File: rtl/pfm_pin_sync.sv
`timescale 1ns/1ps
module pfm_pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Pins in and settled levels out.
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinLevel
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	// ***********************************************************************
	// Three stages; a change counts once stages two and three agree.
	// ***********************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
		end
		else
		begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pinLevel <= '1;
		else
			for (int i = 0; i < WIDTH; i++)
				if (s2_r[i] == s3_r[i])
					pinLevel[i] <= s3_r[i];
	end
endmodule

// File: rtl/pfm_pkg.sv
package pfm_pkg;
	// ***********************************************************************
	// Configuration bit positions.
	// ***********************************************************************
	localparam int PORTD_PER_CAN_TX_BIT = 0;
	localparam int PORTD_PER_CAN_RX_BIT = 1;
	localparam int PSEL_CAN_TX_BIT = 4;
	localparam int PSEL_CAN_RX_BIT = 5;
	localparam int PORTD_PU_DSEL_BIT = 9;
	localparam int PORTD_PU_SELTWO_BIT = 0;
	localparam int PORTD_PU_SELTHREE_BIT = 1;
	localparam int PORTE_PU_TX_BIT = 0;
	localparam int PORTE_PU_RX_BIT = 1;
	localparam int PORT_WIDTH = 16;
	localparam int PSEL_WIDTH = 16;
	localparam int SYNC_STAGES = 3;
	// ***********************************************************************
	// Values after reset.
	// ***********************************************************************
	localparam logic [15:0] PORTD_PER_RESET = 16'h0000;
	localparam logic [15:0] PSEL_RESET = 16'h0000;
	localparam logic [15:0] PULLUP_RESET = 16'hffff;
	localparam logic [1:0] CS_PROG_REGION_RESET = 2'h0;
	localparam logic BUS_DRIVE_RESET = 1'b0;
	localparam logic [1:0] PORTE_SERIAL_RESET = 2'h3;
endpackage

// File: tb/pfm_pin_mux_asserts.sv
`timescale 1ns/1ps
// ****
// Pin checks.
// ****
module pfm_pin_mux_asserts (
	// Controls.
	input logic clk,
	input logic rst_b,
	input logic extDataAccess,
	input logic extBusActive,
	input logic busDriveControl,
	input logic [1:0] csRegionHit,
	input logic [1:0] csProgramEnable,
	input logic [15:0] portDPeripheralEnable,
	input logic [15:0] portDPullupEnable,
	input logic [15:0] portEPullupEnable,
	input logic [1:0] portESerialDisable,
	// Pins.
	input logic [2:0] portDPinOut,
	input logic [2:0] portDPinOe,
	input logic [2:0] portDPinPullup,
	input logic [1:0] portEPinOe,
	input logic [1:0] portEPinPullup
);
	wire selTwo = csProgramEnable[0] && !portDPeripheralEnable[0];
	wire selThree = csProgramEnable[1] && !portDPeripheralEnable[1];
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	property p_dsel; rst_b |=> portDPinOut[0] == !$past(extDataAccess); endproperty
	a_dsel: assert property (p_dsel) else $error("dsel");
	property p_idle; rst_b |=> portDPinOe[0] == $past(extBusActive | busDriveControl); endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_seltwo; selTwo [*3] |-> portDPinOut[1] == !$past(csRegionHit[0]); endproperty
	a_seltwo: assert property (p_seltwo) else $error("seltwo");
	property p_selthree; selThree [*3] |-> portDPinOut[2] == !$past(csRegionHit[1]); endproperty
	a_selthree: assert property (p_selthree) else $error("selthree");
	property p_csoe; selTwo [*3] |-> portDPinOe[1] == $past(extBusActive | busDriveControl);
	endproperty
	a_csoe: assert property (p_csoe) else $error("csoe");
	property p_pull; rst_b |=> portDPinPullup == $past({portDPullupEnable[1:0], portDPullupEnable[9]});
	endproperty
	a_pull: assert property (p_pull) else $error("pull");
	property p_epul; rst_b |=> portEPinPullup == $past(portEPullupEnable[1:0]); endproperty
	a_epul: assert property (p_epul) else $error("epul");
	property p_ser; (!portESerialDisable[0]) [*3] |-> portEPinOe[0]; endproperty
	a_ser: assert property (p_ser) else $error("ser");
	property p_rst; $rose(rst_b) |-> {portDPinOe, portEPinOe} == 5'h00 && &portDPinPullup; endproperty
	a_rst: assert property (p_rst) else $error("rst");
endmodule
bind pfm_pin_mux pfm_pin_mux_asserts u_pfm_pin_mux_asserts (.*);

// File: tb/pfm_pin_mux_bench.sv
`timescale 1ns/1ps
// ****
// Bench.
// ****
module pfm_pin_mux_bench;
	logic clk = 1'h0, rst_b = 1'h0, extDataAccess = 1'h0, extBusActive = 1'h0;
	logic busDriveControl = 1'h0, canTx = 1'h1, serialTx = 1'h1, canRx, serialRx;
	logic [1:0] csRegionHit = 2'h0, csProgramEnable = 2'h0, portESerialDisable = 2'h0;
	logic [1:0] portEOut = 2'h0, portEDir = 2'h0, portEIn, portEPinIn, portEPinOut;
	logic [1:0] portEPinOe, portEPinPullup;
	logic [2:0] portDOut = 3'h0, portDDir = 3'h0, portDIn, portDPinIn, portDPinOut;
	logic [2:0] portDPinOe, portDPinPullup;
	logic [15:0] portDPeripheralEnable = 16'h0000, peripheralSelect = 16'h0000;
	logic [15:0] portDPullupEnable = 16'hffff, portEPullupEnable = 16'hffff;
	logic [4:0] farVal = 5'h00, farEn = 5'h00;
	logic [6:0] rowIn [6] = '{7'h6c, 7'h04, 7'h14, 7'h74, 7'h21, 7'h0a};
	logic [5:0] rowOut [6] = '{6'h38, 6'h00, 6'h3f, 6'h3e, 6'h39, 6'h00};
	int bad_count = 0, comparisons = 0;
	always #2 clk = !clk;
	pfm_pin_mux u_pfm_pin_mux (.*);
	pfm_pin_partner u_pfm_pin_partner (.*);
	task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic test_done;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		tick(8);
		check("rst", {portEPinOe, portDPinOe, portEPinPullup, portDPinPullup}, 10'h01f);
		@(posedge clk);
		rst_b <= 1'h1;
		tick(4);
		check("boot", {5'h0, portEPinOe, portDPinOe}, 10'h008);
		foreach (rowIn[i])
		begin
			@(posedge clk);
			{extDataAccess, extBusActive, busDriveControl} <= rowIn[i][6:4];
			csRegionHit <= {2{rowIn[i][3]}};
			csProgramEnable <= {2{rowIn[i][2]}};
			portDOut <= {{2{rowIn[i][1]}}, 1'h0};
			portDDir <= {{2{rowIn[i][0]}}, 1'h0};
			tick(3);
			check("sel", {4'h0, portDPinOe, portDPinOut & portDPinOe}, {4'h0, rowOut[i]});
		end
		@(posedge clk);
		portDPullupEnable <= 16'hfcfe;
		portEPullupEnable <= 16'hfffd;
		tick(2);
		check("pull", {5'h0, portEPinPullup, portDPinPullup}, 10'h00c);
		@(posedge clk);
		portDDir <= 3'h2;
		portDOut <= 3'h0;
		farEn <= 5'h04;
		portDPeripheralEnable <= 16'h0001;
		tick(6);
		check("gpio", {7'h0, portDIn[2], portDPinOe[2:1]}, 10'h001);
		@(posedge clk);
		peripheralSelect <= 16'h0010;
		canTx <= 1'h0;
		tick(4);
		check("txlo", {8'h0, portDPinOe[1], portDPinOut[1]}, 10'h002);
		@(posedge clk);
		canTx <= 1'h1;
		portDPeripheralEnable <= 16'h0003;
		tick(6);
		check("txhi", {8'h0, portDPinOe[1], canRx}, 10'h001);
		@(posedge clk);
		peripheralSelect <= 16'h0030;
		tick(8);
		check("rx", {9'h0, canRx}, 10'h000);
		@(posedge clk);
		farEn <= 5'h10;
		serialTx <= 1'h0;
		tick(8);
		check("sci", {7'h0, serialRx, portEPinOe[0], portEPinOut[0]}, 10'h002);
		@(posedge clk);
		portESerialDisable <= 2'h3;
		portEDir <= 2'h2;
		portEOut <= 2'h2;
		farEn <= 5'h08;
		tick(8);
		check("gpioe", {3'h0, serialRx, portEIn, portEPinOe, portEPinOut}, 10'h06a);
		@(posedge clk);
		rst_b <= 1'h0;
		tick(2);
		check("rst2", {portEPinOe, portDPinOe, portEPinPullup, portDPinPullup}, 10'h01f);
		@(posedge clk);
		rst_b <= 1'h1;
		tick(2);
		test_done();
	end
	initial
	begin
		#2000;
		bad_count++;
		test_done();
	end
endmodule

// File: tb/pfm_pin_partner.sv
`timescale 1ns/1ps
// ****
// Far side of the pins.
// ****
module pfm_pin_partner (
	// Design pins.
	input logic clk,
	input logic [2:0] portDPinOut,
	input logic [2:0] portDPinOe,
	input logic [2:0] portDPinPullup,
	input logic [1:0] portEPinOut,
	input logic [1:0] portEPinOe,
	input logic [1:0] portEPinPullup,
	// Far drivers and levels.
	input logic [4:0] farVal,
	input logic [4:0] farEn,
	output logic [2:0] portDPinIn,
	output logic [1:0] portEPinIn
);
	logic [4:0] last = 5'h00;
	wire [4:0] oe = {portEPinOe, portDPinOe};
	wire [4:0] pu = {portEPinPullup, portDPinPullup};
	wire [4:0] far = farEn & farVal | ~farEn & (pu | ~last);
	// An undriven pin without pull-up or far driver flips every cycle.
	wire [4:0] lvl = oe & {portEPinOut, portDPinOut} | ~oe & far;
	always @(posedge clk) last <= lvl;
	assign {portEPinIn, portDPinIn} = lvl;
endmodule
